// >>> hdl/card_uart_status.sv
// status, interrupt identification and enable registers of the card uart
`timescale 1ns/10ps
`include "card_uart_map.svh"

// Contract
// - tx empty set on load, cleared by write
// - overflow status follows current monitor
// - supply ok follows voltage monitor
// - timeout set on expiry, cleared on reload
// - sent set on success, cleared by read
// - received set, final failure also sets
// - parity status on final try error
// - status resets to tx empty only
// - ident read only, cleared on read
// - tx empty flag, gated by enable
// - overflow flag, gated by enable
// - supply error flag, gated by enable
// - timeout flag, gated by enable
// - sent flag, gated by enable
// - received flag, gated by enable
// - parity flag with received, or alone on final tx failure
// - bit six reserved in ident
// - enable register bit layout
// - fixed service priority order
module card_uart_status (
    input wire logic mclk,
    input wire logic resetn,
    input card_uart_pkg::sfr_req_s sfr,
    input wire logic register_page_select,
    output logic [7:0] sfr_rdata,
    output logic sfr_rdata_valid,
    input card_uart_pkg::uart_events_s events,
    input wire logic repetition_en,
    input wire logic data_buffer_write,
    input wire logic data_buffer_read,
    input wire logic current_over_pin,
    input wire logic supply_ok_pin,
    output logic irq,
    output card_uart_pkg::irq_src_e irq_source,
    output logic irq_source_valid
);
    import card_uart_pkg::*;

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic pg, input logic [7:0] want,
                                 input logic want_pg);
        hit = (a == want) && (pg == want_pg);
    endfunction

    logic sel_status;
    logic sel_ident;
    logic sel_enable;
    logic status_rd;
    logic ident_rd;
    logic enable_wr;

    assign sel_status = hit(sfr.addr, register_page_select, `STATUS_ADDR, `PAGE_MAIN);
    assign sel_ident = hit(sfr.addr, register_page_select, `IDENT_ADDR, `PAGE_MAIN);
    assign sel_enable = hit(sfr.addr, register_page_select, `ENABLE_ADDR, `PAGE_ALT);
    assign status_rd = sfr.rd && sel_status;
    assign ident_rd = sfr.rd && sel_ident;
    // writes to status and ident are ignored, both are hardware owned
    assign enable_wr = sfr.wr && sel_enable;

    // ------------------------------------------------------------------------
    // analog monitor levels
    // ------------------------------------------------------------------------
    logic [1:0] mon_q;
    logic ovf_q;
    logic volt_q;
    logic volt_d_reg;
    logic ovf_d_reg;

    // one synchroniser lane per monitor level, not one per stage
    bit_sync #(.WIDTH(2)) bit_sync_i (
        .mclk(mclk),
        .resetn(resetn),
        .d({current_over_pin, supply_ok_pin}),
        .q(mon_q)
    );

    assign ovf_q = mon_q[1];
    assign volt_q = mon_q[0];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ovf_d_reg <= 1'h0;
            volt_d_reg <= 1'h0;
        end else begin
            ovf_d_reg <= ovf_q;
            volt_d_reg <= volt_q;
        end
    end

    // ------------------------------------------------------------------------
    // set conditions
    // ------------------------------------------------------------------------
    logic sent_set;
    logic recv_set;
    logic pe_set;
    logic ovf_rise;
    logic volt_fall;

    // with repetition only a good try counts as sent
    assign sent_set = events.tx_done && (!repetition_en || events.tx_ok);
    // a failed final try still lets software read the bad byte
    assign recv_set = events.rx_done &&
                      (!repetition_en || !events.rx_parity_err || events.rx_last_try);
    assign pe_set = repetition_en ?
                    ((events.rx_done && events.rx_parity_err && events.rx_last_try) ||
                     (events.tx_done && !events.tx_ok && events.tx_last_try)) :
                    (events.rx_done && events.rx_parity_err);
    assign ovf_rise = ovf_q && !ovf_d_reg;
    // the synchronisers start low, so leaving range needs a prior in range level
    assign volt_fall = !volt_q && volt_d_reg;

    // ------------------------------------------------------------------------
    // status register bits
    // ------------------------------------------------------------------------
    logic tx_buffer_empty_status;
    logic current_overflow_status;
    logic supply_in_range_status;
    logic wait_timeout_status;
    logic char_sent_status;
    logic char_received_status;
    logic parity_error_status;
    logic [7:0] card_uart_status;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_buffer_empty_status <= 1'h1;
        end else if (events.tx_buf_load) begin
            tx_buffer_empty_status <= 1'h1;
        end else if (data_buffer_write) begin
            tx_buffer_empty_status <= 1'h0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            current_overflow_status <= 1'h0;
            supply_in_range_status <= 1'h0;
        end else begin
            current_overflow_status <= ovf_q;
            supply_in_range_status <= volt_q;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wait_timeout_status <= 1'h0;
        end else if (events.wt_expire) begin
            wait_timeout_status <= 1'h1;
        end else if (events.wt_reload) begin
            wait_timeout_status <= 1'h0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            char_sent_status <= 1'h0;
        end else if (sent_set) begin
            char_sent_status <= 1'h1;
        end else if (status_rd) begin
            char_sent_status <= 1'h0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            char_received_status <= 1'h0;
        end else if (recv_set) begin
            char_received_status <= 1'h1;
        end else if (data_buffer_read) begin
            char_received_status <= 1'h0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            parity_error_status <= 1'h0;
        end else if (pe_set) begin
            parity_error_status <= 1'h1;
        end else if (status_rd) begin
            parity_error_status <= 1'h0;
        end
    end

    always_comb begin
        card_uart_status = 8'h00;
        card_uart_status[`BIT_TBE] = tx_buffer_empty_status;
        card_uart_status[`BIT_OVF] = current_overflow_status;
        card_uart_status[`BIT_VOLT] = supply_in_range_status;
        card_uart_status[`BIT_WTO] = wait_timeout_status;
        card_uart_status[`BIT_SENT] = char_sent_status;
        card_uart_status[`BIT_RECV] = char_received_status;
        card_uart_status[`BIT_PE] = parity_error_status;
    end

    // ------------------------------------------------------------------------
    // interrupt identification flags
    // ------------------------------------------------------------------------
    logic [7:0] flag_set;
    logic [7:0] card_uart_irq_ident_reg;
    logic [7:0] card_uart_irq_ident_next;

    always_comb begin
        flag_set = 8'h00;
        flag_set[`BIT_TBE] = events.tx_buf_load;
        flag_set[`BIT_OVF] = ovf_rise;
        flag_set[`BIT_VOLT] = volt_fall;
        flag_set[`BIT_WTO] = events.wt_expire;
        flag_set[`BIT_SENT] = sent_set;
        flag_set[`BIT_RECV] = recv_set;
        flag_set[`BIT_PE] = pe_set;
    end

    // a read clears everything pending; set in the same cycle survives
    assign card_uart_irq_ident_next = (flag_set | (ident_rd ? 8'h00 : card_uart_irq_ident_reg)) &
                                      `FLAG_MASK;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            card_uart_irq_ident_reg <= `IDENT_RESET;
        end else begin
            card_uart_irq_ident_reg <= card_uart_irq_ident_next;
        end
    end

    // ------------------------------------------------------------------------
    // enable register
    // ------------------------------------------------------------------------
    logic [7:0] card_uart_irq_enable_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            card_uart_irq_enable_reg <= `ENABLE_RESET;
        end else if (enable_wr) begin
            card_uart_irq_enable_reg <= sfr.wdata & `FLAG_MASK;
        end
    end

    // ------------------------------------------------------------------------
    // interrupt request and priority
    // ------------------------------------------------------------------------
    logic [7:0] pending;

    assign pending = card_uart_irq_ident_reg & card_uart_irq_enable_reg;
    assign irq = |pending;

    irq_priority irq_priority_i (
        .pending(pending),
        .src(irq_source),
        .any(irq_source_valid)
    );

    // ------------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------------
    // value is captured before the read clear takes effect
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
            sfr_rdata_valid <= 1'h0;
        end else begin
            sfr_rdata_valid <= sfr.rd;
            if (sfr.rd) begin
                if (sel_status) begin
                    sfr_rdata <= card_uart_status;
                end else if (sel_ident) begin
                    sfr_rdata <= card_uart_irq_ident_reg;
                end else if (sel_enable) begin
                    sfr_rdata <= card_uart_irq_enable_reg;
                end else begin
                    sfr_rdata <= 8'h00;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_TBE_SET: assert property (events.tx_buf_load |=> tx_buffer_empty_status)
        else $error("tx empty status not set on load");
    AST_TBE_CLR: assert property (data_buffer_write && !events.tx_buf_load |=> !tx_buffer_empty_status)
        else $error("tx empty status not cleared on data write");
    AST_OVF_TRACK: assert property (##3 (current_overflow_status == $past(current_over_pin, 3)))
        else $error("overflow status does not track monitor");
    AST_VOLT_TRACK: assert property (##3 (supply_in_range_status == $past(supply_ok_pin, 3)))
        else $error("supply status does not track monitor");
    AST_WTO_HOLD: assert property (events.wt_expire ##1 (!events.wt_reload)[*2] |-> wait_timeout_status)
        else $error("timeout status lost without reload");
    AST_SENT_FAIL: assert property (repetition_en && events.tx_done && !events.tx_ok && !char_sent_status
                                    |=> !char_sent_status)
        else $error("sent status set on failed try");
    AST_RECV_FINAL: assert property (repetition_en && events.rx_done && events.rx_parity_err &&
                                     events.rx_last_try |=> char_received_status && parity_error_status)
        else $error("final failed reception not flagged");
    AST_PE_MIDTRY: assert property (repetition_en && events.rx_done && events.rx_parity_err &&
                                    !events.rx_last_try && !events.tx_done && !parity_error_status
                                    |=> !parity_error_status)
        else $error("parity status set before final try");
    AST_IDENT_CLR: assert property (ident_rd && flag_set == 8'h00 |=> card_uart_irq_ident_reg == 8'h00)
        else $error("ident not cleared by read");
    AST_SET_WINS: assert property (ident_rd && events.wt_expire |=> card_uart_irq_ident_reg[`BIT_WTO])
        else $error("event lost against clearing read");
    AST_IRQ_GATE: assert property (events.tx_buf_load && card_uart_irq_enable_reg[`BIT_TBE] &&
                                   !enable_wr |=> irq)
        else $error("enabled tx empty did not request interrupt");
    AST_IRQ_MASKED: assert property (card_uart_irq_enable_reg == 8'h00 |-> !irq)
        else $error("interrupt with all enables clear");
    AST_PRIO: assert property (pending[`BIT_TBE] |-> irq_source == SRC_TBE)
        else $error("tx empty not top priority");
    AST_RSVD: assert property (!card_uart_irq_ident_reg[`BIT_RSVD])
        else $error("reserved ident bit set");
    AST_WTO_RELOAD: assert property (events.wt_reload && !events.wt_expire |=> !wait_timeout_status)
        else $error("timeout status not cleared on reload");
    AST_SENT_CLR: assert property (status_rd && !sent_set |=> !char_sent_status)
        else $error("sent status not cleared by status read");
    AST_RECV_CLR: assert property (data_buffer_read && !recv_set |=> !char_received_status)
        else $error("received status not cleared by buffer read");
    AST_PE_CLR: assert property (status_rd && !pe_set |=> !parity_error_status)
        else $error("parity status not cleared by status read");
    AST_PE_WITH_CHAR: assert property (events.rx_done && events.rx_parity_err &&
                                       (!repetition_en || events.rx_last_try)
                                       |=> card_uart_irq_ident_reg[`BIT_PE] && card_uart_irq_ident_reg[`BIT_RECV])
        else $error("parity flag not raised with received flag");
    AST_SRC_VALID: assert property (irq_source_valid == irq)
        else $error("source valid differs from interrupt request");

    COV_READ_PENDING: cover property (ident_rd && card_uart_irq_ident_reg != 8'h00);
    COV_FINAL_FAIL: cover property (repetition_en && events.rx_done && events.rx_parity_err &&
                                    events.rx_last_try);
    COV_TWO_SOURCES: cover property (pending[`BIT_TBE] && pending[`BIT_RECV]);
    COV_VOLT_LOSS: cover property (volt_fall ##[1:4] irq);
    COV_CLEAR_RACE: cover property (ident_rd && flag_set != 8'h00);
endmodule

// >>> hdl/card_uart_map.svh
// register map, bit positions and reset values of the card uart status block
`ifndef CARD_UART_MAP_SVH
`define CARD_UART_MAP_SVH

// ----------------------------------------------------------------------------
// addresses and page
// ----------------------------------------------------------------------------
`define STATUS_ADDR 8'had
`define IDENT_ADDR 8'hae
`define ENABLE_ADDR 8'hae
`define PAGE_MAIN 1'h0
`define PAGE_ALT 1'h1

// ----------------------------------------------------------------------------
// bit positions, shared by status, ident and enable
// ----------------------------------------------------------------------------
`define BIT_TBE 7
`define BIT_RSVD 6
`define BIT_OVF 5
`define BIT_VOLT 4
`define BIT_WTO 3
`define BIT_SENT 2
`define BIT_RECV 1
`define BIT_PE 0

// ----------------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------------
`define STATUS_RESET 8'h80
`define IDENT_RESET 8'h00
`define ENABLE_RESET 8'h00
`define FLAG_MASK 8'hbf
`define SYNC_STAGES 2

`endif

// >>> hdl/card_uart_pkg.sv
// types shared by the card uart status block
package card_uart_pkg;

    // ------------------------------------------------------------------------
    // cpu special function register access, one cycle strobes
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } sfr_req_s;

    // ------------------------------------------------------------------------
    // one cycle events from the uart core and waiting time counter
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic tx_buf_load;
        logic tx_done;
        logic tx_ok;
        logic tx_last_try;
        logic rx_done;
        logic rx_parity_err;
        logic rx_last_try;
        logic wt_expire;
        logic wt_reload;
    } uart_events_s;

    // ------------------------------------------------------------------------
    // interrupt source, highest priority first
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_TBE = 3'h0,
        SRC_OVF = 3'h1,
        SRC_VOLT = 3'h3,
        SRC_WTO = 3'h2,
        SRC_SENT = 3'h6,
        SRC_RECV = 3'h7,
        SRC_PE = 3'h5,
        SRC_NONE = 3'h4
    } irq_src_e;

endpackage

// >>> hdl/bit_sync.sv
// two flop synchroniser for a vector of independent levels
`timescale 1ns/10ps
module bit_sync #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    // each bit is a separate level, so no coherency between bits is promised
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// >>> hdl/irq_priority.sv
// fixed priority encoder over the enabled pending interrupt flags
`timescale 1ns/10ps
`include "card_uart_map.svh"
module irq_priority (
    input wire logic [7:0] pending,
    output card_uart_pkg::irq_src_e src,
    output logic any
);
    import card_uart_pkg::*;

    // checked lowest first so that higher sources overwrite
    always_comb begin
        src = SRC_NONE;
        if (pending[`BIT_PE]) src = SRC_PE;
        if (pending[`BIT_RECV]) src = SRC_RECV;
        if (pending[`BIT_SENT]) src = SRC_SENT;
        if (pending[`BIT_WTO]) src = SRC_WTO;
        if (pending[`BIT_VOLT]) src = SRC_VOLT;
        if (pending[`BIT_OVF]) src = SRC_OVF;
        if (pending[`BIT_TBE]) src = SRC_TBE;
        any = |pending;
    end
endmodule

// >>> verif/card_side_model.sv
// far side model: uart core event strobes and card supply monitor levels
`timescale 1ns/10ps
module card_side_model (
    input wire logic mclk,
    output card_uart_pkg::uart_events_s events,
    output logic current_over_pin,
    output logic supply_ok_pin
);
    import card_uart_pkg::*;

    // qualifiers wander between strobes so the design cannot lean on them being low
    function automatic uart_events_s idle_ev();
        uart_events_s e;
        logic [3:0] r;
        r = 4'($urandom);
        e = '0;
        e.tx_ok = r[0];
        e.tx_last_try = r[1];
        e.rx_parity_err = r[2];
        e.rx_last_try = r[3];
        return e;
    endfunction

    initial begin
        events = '0;
        current_over_pin = 1'b0;
        supply_ok_pin = 1'b0;
    end

    // one cycle strobe with its qualifiers, as the uart core reports a finished character
    task automatic fire(input uart_events_s e);
        @(posedge mclk);
        events <= e;
        @(posedge mclk);
        events <= idle_ev();
    endtask

    // monitor levels change with no relation to the bus traffic
    task automatic set_pins(input logic over, input logic ok);
        @(posedge mclk);
        current_over_pin <= over;
        supply_ok_pin <= ok;
    endtask
endmodule

// >>> verif/card_uart_status_irq_flags_test.sv
// self-checking bench for the card uart status and interrupt flag block
`timescale 1ns/10ps
`include "card_uart_map.svh"
module card_uart_status_irq_flags_test;
    import card_uart_pkg::*;

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    sfr_req_s sfr = '0;
    logic register_page_select = 1'b0;
    logic repetition_en = 1'b0;
    logic data_buffer_write = 1'b0;
    logic data_buffer_read = 1'b0;
    logic [7:0] sfr_rdata;
    logic sfr_rdata_valid;
    logic irq;
    irq_src_e irq_source;
    logic irq_source_valid;
    uart_events_s events;
    logic current_over_pin;
    logic supply_ok_pin;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int n_checks = 0;
    logic [31:0] r;
    logic [7:0] en;
    logic [7:0] pend;

    always #2 mclk = ~mclk;

    card_uart_status card_uart_status_i (.mclk(mclk), .resetn(resetn), .sfr(sfr),
        .register_page_select(register_page_select), .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid),
        .events(events), .repetition_en(repetition_en), .data_buffer_write(data_buffer_write),
        .data_buffer_read(data_buffer_read), .current_over_pin(current_over_pin), .supply_ok_pin(supply_ok_pin),
        .irq(irq), .irq_source(irq_source), .irq_source_valid(irq_source_valid));

    card_side_model card_side_model_i (.mclk(mclk), .events(events), .current_over_pin(current_over_pin),
        .supply_ok_pin(supply_ok_pin));

    // ------------------------------------------------------------------------
    // checking and reporting
    // ------------------------------------------------------------------------
    task automatic finish_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic report(input logic [15:0] got, input logic [15:0] exp);
        n_mismatch++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            report({8'h00, got}, {8'h00, exp});
        end
    endtask

    task automatic chk_irq(input logic e, input irq_src_e s);
        @(posedge mclk);
        n_checks++;
        if (irq !== e || irq_source_valid !== e || irq_source !== s) begin
            report({8'h00, irq_source_valid, irq, 3'h0, irq_source}, {8'h00, e, e, 3'h0, s});
        end
    endtask

    // read data is kept from the answer, since the read wipes the flags
    always @(posedge mclk) begin
        if (sfr_rdata_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                report({8'h00, sfr_rdata}, 16'hffff);
            end else begin
                chk8(sfr_rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end

    // ------------------------------------------------------------------------
    // stimulus tasks
    // ------------------------------------------------------------------------
    task automatic bus(input logic rq, input logic w, input logic [7:0] a, input logic p, input logic [7:0] d);
        @(posedge mclk);
        sfr <= '{addr: a, rd: rq, wr: w, wdata: d};
        register_page_select <= p;
        @(posedge mclk);
        sfr <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic p, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b1, 1'b0, a, p, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic p, input logic [7:0] d);
        bus(1'b0, 1'b1, a, p, d);
    endtask

    task automatic ev(input logic [8:0] v);
        card_side_model_i.fire(uart_events_s'(v));
    endtask

    task automatic buf_op(input logic w, input logic rq);
        @(posedge mclk);
        data_buffer_write <= w;
        data_buffer_read <= rq;
        @(posedge mclk);
        data_buffer_write <= 1'b0;
        data_buffer_read <= 1'b0;
    endtask

    task automatic pins(input logic over, input logic ok);
        card_side_model_i.set_pins(over, ok);
        repeat (5) @(posedge mclk);
    endtask

    function automatic irq_src_e top_src(input logic [7:0] p);
        if (p[7]) return SRC_TBE;
        else if (p[5]) return SRC_OVF;
        else if (p[4]) return SRC_VOLT;
        else if (p[3]) return SRC_WTO;
        else if (p[2]) return SRC_SENT;
        else if (p[1]) return SRC_RECV;
        else if (p[0]) return SRC_PE;
        return SRC_NONE;
    endfunction

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(32'hdcbb4dd5));
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        rd(`STATUS_ADDR, 1'b0, 8'h80);
        rd(`IDENT_ADDR, 1'b0, 8'h00);
        rd(`ENABLE_ADDR, 1'b1, 8'h00);
        rd(8'h10, 1'b0, 8'h00);
        chk_irq(1'b0, SRC_NONE);
        wr(`ENABLE_ADDR, 1'b1, 8'hbf);
        rd(`ENABLE_ADDR, 1'b1, 8'hbf);
        wr(`STATUS_ADDR, 1'b0, 8'h00);
        wr(`IDENT_ADDR, 1'b0, 8'hbf);
        rd(`STATUS_ADDR, 1'b0, 8'h80);
        rd(`IDENT_ADDR, 1'b0, 8'h00);
        buf_op(1'b1, 1'b0);
        rd(`STATUS_ADDR, 1'b0, 8'h00);
        ev(9'h100);
        chk_irq(1'b1, SRC_TBE);
        rd(`STATUS_ADDR, 1'b0, 8'h80);
        rd(`IDENT_ADDR, 1'b0, 8'h80);
        rd(`IDENT_ADDR, 1'b0, 8'h00);
        chk_irq(1'b0, SRC_NONE);
        wr(`ENABLE_ADDR, 1'b1, 8'h00);
        ev(9'h100);
        chk_irq(1'b0, SRC_NONE);
        rd(`IDENT_ADDR, 1'b0, 8'h80);
        wr(`ENABLE_ADDR, 1'b1, 8'hbf);
        ev(9'h002);
        chk_irq(1'b1, SRC_WTO);
        rd(`STATUS_ADDR, 1'b0, 8'h88);
        rd(`STATUS_ADDR, 1'b0, 8'h88);
        ev(9'h001);
        rd(`STATUS_ADDR, 1'b0, 8'h80);
        rd(`IDENT_ADDR, 1'b0, 8'h08);
        ev(9'h0c0);
        chk_irq(1'b1, SRC_SENT);
        rd(`STATUS_ADDR, 1'b0, 8'h84);
        rd(`STATUS_ADDR, 1'b0, 8'h80);
        rd(`IDENT_ADDR, 1'b0, 8'h04);
        @(posedge mclk);
        repetition_en <= 1'b1;
        ev(9'h0a0);
        rd(`STATUS_ADDR, 1'b0, 8'h81);
        rd(`IDENT_ADDR, 1'b0, 8'h01);
        ev(9'h080);
        ev(9'h018);
        rd(`STATUS_ADDR, 1'b0, 8'h80);
        rd(`IDENT_ADDR, 1'b0, 8'h00);
        ev(9'h01c);
        rd(`STATUS_ADDR, 1'b0, 8'h83);
        rd(`STATUS_ADDR, 1'b0, 8'h82);
        buf_op(1'b0, 1'b1);
        rd(`STATUS_ADDR, 1'b0, 8'h80);
        rd(`IDENT_ADDR, 1'b0, 8'h03);
        @(posedge mclk);
        repetition_en <= 1'b0;
        ev(9'h018);
        rd(`STATUS_ADDR, 1'b0, 8'h83);
        buf_op(1'b0, 1'b1);
        rd(`STATUS_ADDR, 1'b0, 8'h80);
        rd(`IDENT_ADDR, 1'b0, 8'h03);
        pins(1'b1, 1'b0);
        rd(`STATUS_ADDR, 1'b0, 8'ha0);
        chk_irq(1'b1, SRC_OVF);
        rd(`IDENT_ADDR, 1'b0, 8'h20);
        pins(1'b0, 1'b1);
        rd(`STATUS_ADDR, 1'b0, 8'h90);
        rd(`IDENT_ADDR, 1'b0, 8'h00);
        pins(1'b0, 1'b0);
        rd(`STATUS_ADDR, 1'b0, 8'h80);
        chk_irq(1'b1, SRC_VOLT);
        rd(`IDENT_ADDR, 1'b0, 8'h10);
        fork
            ev(9'h002);
            rd(`IDENT_ADDR, 1'b0, 8'h00);
        join
        rd(`IDENT_ADDR, 1'b0, 8'h08);
        fork
            ev(9'h0c0);
            rd(`STATUS_ADDR, 1'b0, 8'h88);
        join
        rd(`STATUS_ADDR, 1'b0, 8'h8c);
        rd(`IDENT_ADDR, 1'b0, 8'h04);
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            en = r[15:8] & 8'hbf;
            pend = {r[0], 3'h0, r[1], r[2], r[3], r[3] & r[4]};
            wr(`ENABLE_ADDR, 1'b1, en);
            ev({r[0], r[2], 1'b1, 1'b0, r[3], r[4], 1'b0, r[1], 1'b0});
            chk_irq(|(pend & en), top_src(pend & en));
            rd(`IDENT_ADDR, 1'b0, pend);
        end
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) begin
            @(posedge mclk);
        end
        if (exp_q.size() > 0) begin
            n_mismatch++;
        end
        finish_test();
    end
endmodule
